// ==== cipher_glue_pkg.sv ====
// Purpose: Shared constants for the CPU to cipher port glue.
// Assumes: One system clock of 100 MHz drives every flip-flop.
// Notes: Strobes and selects are active low and rest high.
package cipher_glue_pkg;

    // Reset and idle level of every active-low strobe and select.
    localparam logic STROBE_IDLE = 1'b1;
    // Reset level of the divided cipher clock.
    localparam logic CIPHER_CLK_RESET = 1'b0;
    // Reset value of the held read data.
    localparam logic [7:0] RDATA_RESET = 8'h00;
    // Number of stages in each pin synchroniser.
    localparam int SYNC_STAGES = 2;
    // Width of the synchronised pin bundle: five control pins and a data byte.
    localparam int PIN_WIDTH = 13;
    // Reset value of the pin bundle: control pins inactive, mode A strap high.
    localparam logic [12:0] PIN_RESET = 13'h1FFF;
    // Bit positions inside the pin bundle.
    localparam int PIN_IOREQ = 12;
    localparam int PIN_CS = 11;
    localparam int PIN_LSB = 10;
    localparam int PIN_WR = 9;
    localparam int PIN_MODE = 8;
    // Highest system clock in MHz for which mode A is meant.
    localparam int MODE_A_MAX_MHZ = 4;

    // Access sequencer states.
    typedef enum logic [2:0] {
        idle_st,
        latch_st,
        wr1_st,
        wr2_st,
        rd1_st,
        rd2_st,
        rdhold_st,
        hold_st
    } seq_state_type;

endpackage

// ==== pin_sync.sv ====
// Purpose: Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes: Each bit is a level; the bundle is not sampled as one word.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Asynchronous pins and their synchronised copies.
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_sync
);

    logic [WIDTH-1:0] stage1_reg;

    // Both stages load a constant under reset and sample on every rising edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= RESET_VAL;
            pins_sync <= RESET_VAL;
        end else begin
            stage1_reg <= pins_in;
            pins_sync <= stage1_reg;
        end
    end

endmodule // pin_sync

// ==== cpu_to_cipher_port_glue.sv ====
// Purpose: Glue between an 8-bit CPU I/O bus and a multiplexed cipher port.
// Assumes: CPU pins are asynchronous and pass a two-stage synchroniser.
// Notes: The mode strap is sampled continuously and must stay fixed.
// Function
// R1 - Even address latches, odd address transfers data.
// R2 - Latched register address stays until next strobe.
// R3 - Data strobe rises with cipher clock falling.
// R4 - Mode A: inverted system clock, no wait.
// R5 - Mode B: cipher clock is system clock halved.
// R6 - Mode B: realign divided clock to data strobe.
// R7 - Mode B write gets exactly one extra wait.
// R8 - Strap high selects mode A, low B.
// R9 - Port select only when request, select, even.
// R10 - Address strobe pulses low one clock.
// R11 - Read: strobe low two clocks, no wait.
// R12 - Mode B read forces clock high, third state.
// R13 - Read data held until next access begins.
// R14 - Write: one byte, select and address idle.
// R15 - Mode A write: strobe low one clock.
// R16 - Mode B write: strobe low two clocks.
// R17 - Wait driven only in first mode B wait.
// R18 - All flip-flops update on rising clock.
// R19 - Read at even address gives no strobe.
// R20 - Idle: strobes high, wait released.
// R21 - Software latches data register before transfers.
`timescale 1ns/100ps
module cpu_to_cipher_port_glue
    import cipher_glue_pkg::*;
(
    // System clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // CPU I/O bus pins.
    input wire logic io_request_b,
    input wire logic cs_b,
    input wire logic address_lsb,
    input wire logic wr_b,
    // Mode strap: high for mode A, low for mode B.
    input wire logic mode_a_sel,
    // CPU wait request, open drain.
    output logic wait_out,
    output logic wait_oe_b,
    // Read data toward the CPU bus.
    output logic [7:0] cpu_rdata,
    output logic cpu_rdata_oe_b,
    // Cipher port controls.
    output logic port_select_b,
    output logic port_addr_strobe_b,
    output logic port_data_strobe_b,
    output logic cipher_clk,
    output logic addr_selected,
    // Data returned by the cipher port.
    input wire logic [7:0] port_rdata
);

    logic [PIN_WIDTH-1:0] pins_s;
    wire access;
    wire lsb_s;
    wire wr_s;
    wire mode_a;
    wire start_latch;
    wire start_bad_read;
    wire start_write;
    wire start_read;
    wire force_high;
    wire q_read;
    wire in_read;
    seq_state_type state_reg;
    seq_state_type state_next;
    logic sel_b_reg;
    logic sel_b_next;
    logic as_b_reg;
    logic as_b_next;
    logic ds_b_reg;
    logic ds_b_next;
    logic wait_oe_b_reg;
    logic wait_oe_b_next;
    logic clkb_reg;
    logic clkb_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic drive_b_reg;
    logic drive_b_next;
    logic latched_reg;
    logic latched_next;

    // Every pin, including the strap and the cipher data, is synchronised.
    pin_sync #(
        .WIDTH(PIN_WIDTH),
        .RESET_VAL(PIN_RESET)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pins_in({io_request_b, cs_b, address_lsb, wr_b, mode_a_sel, port_rdata}),
        .pins_sync(pins_s)
    );

    // Decode of the synchronised bus.
    assign access = !pins_s[PIN_IOREQ] && !pins_s[PIN_CS];
    assign lsb_s = pins_s[PIN_LSB];
    assign wr_s = !pins_s[PIN_WR];
    assign mode_a = pins_s[PIN_MODE]; // R8
    assign start_latch = access && !lsb_s && wr_s; // R1
    assign start_bad_read = access && !lsb_s && !wr_s; // R19
    assign start_write = access && lsb_s && wr_s; // R1 R14
    assign start_read = access && lsb_s && !wr_s; // R1
    assign in_read = (state_next == rd1_st) || (state_next == rd2_st);

    // Sequencer: each access runs once, then waits for the bus to let go.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            idle_st: begin
                if (start_latch) begin
                    state_next = latch_st;
                end else if (start_bad_read) begin
                    state_next = hold_st; // R19
                end else if (start_write) begin
                    state_next = wr1_st;
                end else if (start_read) begin
                    state_next = rd1_st;
                end
            end
            latch_st: begin
                state_next = hold_st; // R10
            end
            wr1_st: begin
                state_next = mode_a ? hold_st : wr2_st; // R15 R16
            end
            wr2_st: begin
                state_next = hold_st;
            end
            rd1_st: begin
                state_next = rd2_st; // R11
            end
            rd2_st: begin
                state_next = rdhold_st;
            end
            rdhold_st: begin
                state_next = access ? rdhold_st : idle_st;
            end
            hold_st: begin
                state_next = access ? hold_st : idle_st;
            end
        endcase
    end

    // Port select follows an even-address access; address strobe once.
    assign sel_b_next = !(access && !lsb_s); // R9 R14
    assign as_b_next = !(state_next == latch_st); // R10 R20
    // Data strobe covers the first access cycle and, for reads or mode B, one more.
    assign ds_b_next = !((state_next == wr1_st) || (state_next == wr2_st) || in_read); // R11 R15 R16
    // Wait is pulled only in the first wait of a mode B write.
    assign wait_oe_b_next = !((state_next == wr1_st) && !mode_a); // R7 R17 R4
    // Internal read signal of mode B, active in the first read strobe cycle only.
    assign q_read = (state_reg == rd1_st) && !mode_a; // R12
    // Force the divided clock high so it falls as the strobe rises.
    assign force_high = (!mode_a && (state_next == wr2_st)) || q_read; // R6 R12
    assign clkb_next = force_high ? 1'b1 : !clkb_reg; // R5
    // Read data tracks the port during the strobe and then freezes.
    assign rdata_next = in_read ? pins_s[7:0] : rdata_reg; // R13
    assign drive_b_next = !(in_read || (state_next == rdhold_st)); // R13
    // An address strobe marks the port register as selected from then on.
    assign latched_next = latched_reg || (state_next == latch_st); // R2

    // State and registered outputs, all on the rising clock edge.
    always_ff @(posedge clk or negedge rst_b) begin // R18
        if (!rst_b) begin
            state_reg <= idle_st;
            sel_b_reg <= STROBE_IDLE;
            as_b_reg <= STROBE_IDLE;
            ds_b_reg <= STROBE_IDLE;
            wait_oe_b_reg <= STROBE_IDLE;
        end else begin
            state_reg <= state_next;
            sel_b_reg <= sel_b_next;
            as_b_reg <= as_b_next;
            ds_b_reg <= ds_b_next;
            wait_oe_b_reg <= wait_oe_b_next;
        end
    end

    // Divided clock, read data and selection flag.
    always_ff @(posedge clk or negedge rst_b) begin // R18
        if (!rst_b) begin
            clkb_reg <= CIPHER_CLK_RESET;
            rdata_reg <= RDATA_RESET;
            drive_b_reg <= STROBE_IDLE;
            latched_reg <= 1'b0;
        end else begin
            clkb_reg <= clkb_next;
            rdata_reg <= rdata_next;
            drive_b_reg <= drive_b_next;
            latched_reg <= latched_next;
        end
    end

    // Mode A passes the inverted system clock so its fall meets the strobe edge.
    assign cipher_clk = mode_a ? !clk : clkb_reg; // R3 R4
    assign port_select_b = sel_b_reg;
    assign port_addr_strobe_b = as_b_reg;
    assign port_data_strobe_b = ds_b_reg;
    assign wait_out = 1'b0; // R17
    assign wait_oe_b = wait_oe_b_reg;
    assign cpu_rdata = rdata_reg;
    assign cpu_rdata_oe_b = drive_b_reg;
    assign addr_selected = latched_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Port select reflects the even-address decode one clock later.
    property p_select_decode;
        ##1 (port_select_b == !$past(access && !lsb_s));
    endproperty
    a_select_decode: assert property (p_select_decode) // R9
        else $error("port select does not follow the even-address decode");

    // The address strobe is low for exactly one clock.
    property p_as_one_clock;
        $fell(port_addr_strobe_b) |=> port_addr_strobe_b;
    endproperty
    a_as_one_clock: assert property (p_as_one_clock) // R10
        else $error("address strobe longer than one clock");

    // An address strobe only follows an even-address write.
    property p_as_cause;
        $fell(port_addr_strobe_b) |-> $past(start_latch) && !port_select_b;
    endproperty
    a_as_cause: assert property (p_as_cause) // R19
        else $error("address strobe without an address write");

    // Mode A write: strobe low one clock, no wait.
    property p_wr_mode_a;
        (state_reg == idle_st) && start_write && mode_a
            |=> !port_data_strobe_b && wait_oe_b ##1 port_data_strobe_b;
    endproperty
    a_wr_mode_a: assert property (p_wr_mode_a) // R15
        else $error("mode A write strobe is not one clock");

    // Mode B write: strobe low two clocks, wait only in the first.
    property p_wr_mode_b;
        (state_reg == idle_st) && start_write && !mode_a
            |=> (!port_data_strobe_b && !wait_oe_b) ##1 (!port_data_strobe_b && wait_oe_b)
            ##1 port_data_strobe_b;
    endproperty
    a_wr_mode_b: assert property (p_wr_mode_b) // R16
        else $error("mode B write strobe or wait is wrong");

    // Wait is driven only in a mode B write.
    property p_wait_cause;
        !wait_oe_b |-> (state_reg == wr1_st) && !mode_a;
    endproperty
    a_wait_cause: assert property (p_wait_cause) // R7
        else $error("wait driven outside a mode B write");

    // Reads hold the strobe low for two clocks and never add a wait.
    property p_read_strobe;
        (state_reg == idle_st) && start_read
            |=> (!port_data_strobe_b && wait_oe_b) [*2] ##1 port_data_strobe_b;
    endproperty
    a_read_strobe: assert property (p_read_strobe) // R11
        else $error("read strobe is not two clocks");

    // In mode B the divided clock falls as the data strobe rises.
    property p_align;
        $rose(port_data_strobe_b) && !mode_a |-> $fell(clkb_reg);
    endproperty
    a_align: assert property (p_align) // R3
        else $error("cipher clock not aligned to the data strobe");

    // Without a forced phase the divided clock toggles every edge.
    property p_divide;
        !mode_a && !$past(force_high) |-> clkb_reg != $past(clkb_reg);
    endproperty
    a_divide: assert property (p_divide) // R5
        else $error("divided cipher clock failed to toggle");

    // Held read data stays stable until the drive is released.
    property p_rdata_hold;
        (state_reg == rdhold_st) && $past(state_reg == rdhold_st)
            |-> $stable(cpu_rdata) && !cpu_rdata_oe_b;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) // R13
        else $error("read data changed while held");

    // Once idle with no access, every strobe rests high.
    property p_idle;
        (state_reg == idle_st) && $past(state_reg == idle_st) && !$past(access)
            |-> port_addr_strobe_b && port_data_strobe_b && wait_oe_b;
    endproperty
    a_idle: assert property (p_idle) // R20
        else $error("strobe active while idle");

    // The selection flag is set with the first address strobe and never drops.
    property p_selected_hold;
        addr_selected |=> addr_selected;
    endproperty
    a_selected_hold: assert property (p_selected_hold) // R2
        else $error("register selection flag dropped");

    // A data write leaves port select and address strobe idle throughout.
    property p_write_idle;
        (state_reg == idle_st) && start_write
            |=> (port_select_b && port_addr_strobe_b) [*2];
    endproperty
    a_write_idle: assert property (p_write_idle) // R14
        else $error("select or address strobe active in a data write");

endmodule // cpu_to_cipher_port_glue

// ==== cpu_bus_model.sv ====
// Purpose: CPU I/O bus master that performs one access at a time.
// Assumes: The wait pin has a pull-up and is resolved by the bench.
// Notes: Pins change 1 ns after a rising edge and hold until release.
`timescale 1ns/100ps
module cpu_bus_model (
    // Clock and wait pin.
    input wire logic clk,
    input wire logic wait_n,
    // I/O bus pins.
    output logic io_request_b,
    output logic cs_b,
    output logic address_lsb,
    output logic wr_b
);
    // The bus rests released.
    initial begin
        io_request_b = 1'b1;
        cs_b = 1'b1;
        address_lsb = 1'b0;
        wr_b = 1'b1;
    end

    // One access of six cycles, stretched by each wait sampled low.
    task automatic access(input logic lsb, input logic wr, output int waits);
        int left;
        waits = 0;
        left = 6;
        @(posedge clk);
        #1;
        address_lsb = lsb;
        wr_b = ~wr;
        io_request_b = 1'b0;
        cs_b = 1'b0;
        while (left > 0 && waits < 8) begin
            @(posedge clk);
            if (wait_n === 1'b0) waits++;
            else left--;
        end
        #1;
        io_request_b = 1'b1;
        cs_b = 1'b1;
        wr_b = 1'b1;
        address_lsb = ~lsb; // A released address does not keep its value.
        repeat (4) @(posedge clk);
    endtask
endmodule // cpu_bus_model

// ==== cpu_to_cipher_port_glue_tb.sv ====
// Purpose: Self-checking bench for the CPU to cipher port glue.
// Assumes: One 100 MHz clock; the strap changes only under reset.
// Notes: Strobe cycles are counted at falling edges, where they are settled.
`timescale 1ns/100ps
module cpu_to_cipher_port_glue_tb;
    import cipher_glue_pkg::*;
    logic clk, rst_b, mode_a_sel, wait_out, wait_oe_b, cpu_rdata_oe_b;
    logic port_select_b, port_addr_strobe_b, port_data_strobe_b;
    logic cipher_clk, addr_selected, io_request_b, cs_b, address_lsb, wr_b;
    logic [7:0] cpu_rdata, port_rdata;
    logic prev_ds, prev_ck;
    int errors, n_compared, cycles, as_n, ds_n, sel_n, oe_n, ck_t, waits;
    // The wait pin is pulled up whenever the glue releases it.
    wire wait_n = wait_oe_b ? 1'b1 : wait_out;

    cpu_bus_model cpu (.clk(clk), .wait_n(wait_n), .io_request_b(io_request_b),
        .cs_b(cs_b), .address_lsb(address_lsb), .wr_b(wr_b));
    cpu_to_cipher_port_glue uut (.clk(clk), .rst_b(rst_b), .io_request_b(io_request_b),
        .cs_b(cs_b), .address_lsb(address_lsb), .wr_b(wr_b), .mode_a_sel(mode_a_sel),
        .wait_out(wait_out), .wait_oe_b(wait_oe_b), .cpu_rdata(cpu_rdata),
        .cpu_rdata_oe_b(cpu_rdata_oe_b), .port_select_b(port_select_b),
        .port_addr_strobe_b(port_addr_strobe_b), .port_data_strobe_b(port_data_strobe_b),
        .cipher_clk(cipher_clk), .addr_selected(addr_selected), .port_rdata(port_rdata));

    // Clock and time-zero levels.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        mode_a_sel = 1'b1;
        port_rdata = 8'h00;
    end

    // Compares one value and counts the comparison.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Counts low cycles, checks strobe and clock alignment, bounds the run.
    always @(negedge clk) begin
        cycles++;
        if (port_addr_strobe_b === 1'b0) as_n++;
        if (port_data_strobe_b === 1'b0) ds_n++;
        if (port_select_b === 1'b0) sel_n++;
        if (cpu_rdata_oe_b === 1'b0) oe_n++;
        if (cipher_clk !== prev_ck) ck_t++;
        if (!mode_a_sel && prev_ds === 1'b0 && port_data_strobe_b === 1'b1)
            check({7'h00, prev_ck & ~cipher_clk}, 8'h01);
        prev_ds = port_data_strobe_b;
        prev_ck = cipher_clk;
        if (cycles > 5000) begin
            errors++;
            close_out();
        end
    end

    // Resets with the strap set and checks the resting outputs.
    task automatic reset(input logic mode_a);
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        mode_a_sel = mode_a;
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({2'b00, port_select_b, port_addr_strobe_b, port_data_strobe_b, wait_oe_b,
            cpu_rdata_oe_b, addr_selected}, 8'h3E);
    endtask

    // Runs one access with cleared counters.
    task automatic go(input logic lsb, input logic wr);
        as_n = 0;
        ds_n = 0;
        sel_n = 0;
        oe_n = 0;
        cpu.access(lsb, wr, waits);
    endtask

    // Address latch selects the register; one-clock address strobe.
    task automatic t_latch;
        go(1'b0, 1'b1);
        check(8'(as_n), 8'h01);
        check(8'(sel_n > 0), 8'h01);
        check(8'(ds_n), 8'h00);
        check({7'h00, addr_selected}, 8'h01);
        check({6'h00, port_select_b, wait_oe_b}, 8'h03);
    endtask

    // Data write: strobe width and added wait depend on the mode.
    task automatic t_write(input int ds_exp, input int wt_exp);
        go(1'b1, 1'b1);
        check(8'(ds_n), 8'(ds_exp));
        check(8'(waits), 8'(wt_exp));
        check(8'(as_n + sel_n), 8'h00);
        check({7'h00, addr_selected}, 8'h01);
    endtask

    // Data read: two-clock strobe, no wait, data held after the access.
    task automatic t_read(input logic [7:0] val);
        @(posedge clk);
        #1;
        port_rdata = val;
        go(1'b1, 1'b0);
        #1;
        port_rdata = ~val;
        #20;
        check(cpu_rdata, val);
        check(8'(ds_n), 8'h02);
        check(8'(waits), 8'h00);
        check(8'(as_n + sel_n), 8'h00);
        check(8'(oe_n > 0), 8'h01);
        check({7'h00, cpu_rdata_oe_b}, 8'h01);
    endtask

    // Read at an even address must give no strobe at all.
    task automatic t_bad_read;
        go(1'b0, 1'b0);
        check(8'(as_n), 8'h00);
        check(8'(ds_n), 8'h00);
    endtask

    // Mode A clock is the system clock inverted.
    task automatic t_clk_a;
        @(posedge clk);
        #2;
        check({7'h00, cipher_clk}, 8'h00);
        @(negedge clk);
        #2;
        check({7'h00, cipher_clk}, 8'h01);
    endtask

    // Mode B clock toggles on every rising system clock edge while idle.
    task automatic t_clk_b;
        @(posedge clk);
        ck_t = 0;
        repeat (8) @(posedge clk);
        check(8'(ck_t), 8'h08);
    endtask

    // Main sequence: mode A, then mode B after a second reset.
    initial begin
        reset(1'b1);
        t_clk_a();
        t_latch();
        t_write(1, 0);
        t_write(1, 0);
        t_read(8'hA5);
        t_bad_read();
        reset(1'b0);
        t_clk_b();
        t_latch();
        t_write(2, 1);
        t_read(8'h3C);
        t_write(2, 1);
        t_bad_read();
        close_out();
    end
endmodule // cpu_to_cipher_port_glue_tb
